// ==== logic/mag_pkg.sv ====
// constants and types of the mode and access guard
// Overview of operation
// [R01] boot picks system mode when test is available, else user mode
// [R02] only system to user switch, by long call to one address; no return
// [R03] blown delivery fuse makes test software selection impossible
// [R04] only boot and test code run privileged; application gets user mode only
// [R05] user mode cannot change fuse held security configuration
// [R06] top 128 eeprom bytes appear only at reserved logical addresses
// [R07] user mode reads only a defined byte subset of the reserved row
// [R08] rom split in two; user mode reaches only the application part
// [R09] no instruction fetch from the application part in privileged mode
// [R10] user mode may only read the row; privileged mode has full eeprom access
// [R11] partition boundaries are fixed constants, unchangeable by software
// [R12] accesses outside implemented ranges force a system reset
// [R13] cache and ram address and data consistency is checked continuously
// [R14] each special register is granted per function and current mode
// [R15] denied or missing special register reads return a fixed value
// [R16] denied or missing special register writes force a system reset
// [R17] user mode never holds any privileged access right
// [R18] reset cause indicator stays valid after each reset while powered
// [R19] factory key area is 64 bytes at the start of the row
// [R20] a violation reset restarts the boot decision
`default_nettype none

package mag_pkg;

  // ==========================================================================
  // modes and access kinds
  typedef enum logic [1:0] {MD_BOOT, MD_SYSTEM, MD_USER} mag_mode_t;

  localparam logic [1:0] KIND_FETCH = 2'h0;
  localparam logic [1:0] KIND_READ  = 2'h1;
  localparam logic [1:0] KIND_WRITE = 2'h2;

  localparam logic [1:0] SPC_CODE  = 2'h0;
  localparam logic [1:0] SPC_XDATA = 2'h1;
  localparam logic [1:0] SPC_REG   = 2'h2;

  // ==========================================================================
  // fixed memory partitions
  localparam logic [15:0] ROM_USR_BASE  = 16'h2000;
  localparam logic [15:0] ROM_USR_END   = 16'h9FFF;
  localparam logic [15:0] MODE_SW_ADDR  = 16'h2000;
  localparam logic [15:0] EEP_USR_END   = 16'h0F7F;
  localparam logic [15:0] ROW_PHYS_BASE = 16'h0F80;
  localparam logic [15:0] ROW_LOG_BASE  = 16'hF000;
  localparam logic [15:0] ROW_LOG_END   = 16'hF07F;
  localparam logic [6:0]  FAB_LAST      = 7'h3F;
  localparam logic [6:0]  ROW_URD_LAST  = 7'h1F;
  localparam logic [6:0]  ROW_UCFG_BASE = 7'h40;
  localparam logic [15:0] RAM_BASE      = 16'h1000;
  localparam logic [15:0] RAM_END       = 16'h17FF;

  // ==========================================================================
  // special function register classes
  localparam logic [15:0] REG_LO        = 16'h0080;
  localparam logic [15:0] REG_HI        = 16'h00FF;
  localparam logic [7:0]  REG_UCFG_BASE = 8'hC0;
  localparam logic [7:0]  REG_SYS_BASE  = 8'hE0;
  localparam logic [7:0]  REG_NIMP_BASE = 8'hF0;
  localparam logic [7:0]  REG_FIXED_VAL = 8'hFF;

  // ==========================================================================
  // reset causes and reset values
  localparam logic [2:0] CS_POWER = 3'h0;
  localparam logic [2:0] CS_RANGE = 3'h1;
  localparam logic [2:0] CS_MEM   = 3'h2;
  localparam logic [2:0] CS_REG   = 3'h3;
  localparam logic [2:0] CS_CONS  = 3'h4;
  localparam logic [2:0] CS_FUSE  = 3'h5;
  localparam logic [2:0] CS_NONE  = 3'h7;
  localparam logic [7:0] RDATA_RST = 8'h00;

endpackage

`default_nettype wire

// ==== logic/mag_sync3.sv ====
// three stage synchroniser for a pin level
`timescale 1ns/10ps
`default_nettype none

module mag_sync3 (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // pin level and clean level
  input  wire logic d_in,
  output logic      q_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } mag_sync_t;

  mag_sync_t st;
  mag_sync_t next_st;

  // ==========================================================================
  // a change counts once stages two and three agree
  always_comb begin
    next_st    = st;
    next_st.s1 = d_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.q = st.s3;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_out = st.q;

endmodule

`default_nettype wire

// ==== logic/mag_guard.sv ====
// mode controller and memory and register access guard
`timescale 1ns/10ps
`default_nettype none

module mag_guard (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // pins
  input  wire logic        test_pin_in,
  input  wire logic        fuse_blown_in,
  // boot decision from boot code
  input  wire logic        boot_done_in,
  input  wire logic        boot_test_sel_in,
  // cpu access
  input  wire logic        acc_valid_in,
  input  wire logic [1:0]  acc_kind_in,
  input  wire logic [1:0]  acc_space_in,
  input  wire logic [15:0] acc_addr_in,
  input  wire logic [7:0]  acc_wdata_in,
  input  wire logic        long_call_instruction_in,
  input  wire logic [15:0] long_call_target_in,
  input  wire logic        fuse_wr_in,
  // memory side
  input  wire logic [7:0]  mem_rdata_in,
  input  wire logic        mem_par_in,
  input  wire logic        cache_valid_in,
  input  wire logic [15:0] cache_addr_in,
  input  wire logic [7:0]  cache_data_in,
  input  wire logic        cache_par_in,
  // memory control
  output logic             mem_en_out,
  output logic             mem_we_out,
  output logic [15:0]      mem_addr_out,
  output logic             ram_par_out,
  output logic             fuse_wr_en_out,
  // answers and status
  output logic             rsp_valid_out,
  output logic [7:0]       rsp_rdata_out,
  output logic             privileged_out,
  output logic             sys_reset_out,
  output logic [2:0]       reset_cause_out
);

  typedef struct packed {
    mag_pkg::mag_mode_t mode;
    logic               rsp_valid;
    logic [7:0]         rdata;
    logic               sys_reset;
    logic [2:0]         cause;
  } mag_state_t;

  mag_state_t  st;
  mag_state_t  next_st;
  logic        test_pin_s;
  logic        fuse_s;
  logic        user;
  logic        v_range;
  logic        v_right;
  logic        v_reg;
  logic        rd_block;
  logic        in_ram;
  logic        c_err;
  logic [2:0]  cause_c;
  logic [15:0] phys;
  logic [6:0]  row_off;

  // ==========================================================================
  // functions
  function automatic logic par(input logic [15:0] a, input logic [7:0] d);
    par = ^{a, d};
  endfunction

  // register permission by address class and mode
  function automatic logic reg_ok(input logic [7:0] a, input logic usr, input logic wr);
    if (a >= mag_pkg::REG_NIMP_BASE) begin
      reg_ok = 1'b0;
    end else if (a >= mag_pkg::REG_SYS_BASE) begin
      reg_ok = !usr;
    end else if (a >= mag_pkg::REG_UCFG_BASE) begin
      reg_ok = !(usr && wr);
    end else begin
      reg_ok = 1'b1;
    end
  endfunction

  // user readable subset of the reserved row
  function automatic logic row_user_rd(input logic [6:0] off);
    row_user_rd = (off <= mag_pkg::ROW_URD_LAST) || (off >= mag_pkg::ROW_UCFG_BASE);
  endfunction

  // ==========================================================================
  // pin synchronisers
  mag_sync3 u_sync_test (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .d_in    (test_pin_in),
    .q_out   (test_pin_s)
  );

  mag_sync3 u_sync_fuse (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .d_in    (fuse_blown_in),
    .q_out   (fuse_s)
  );

  assign user    = (st.mode == mag_pkg::MD_USER);
  assign row_off = acc_addr_in[6:0];
  assign in_ram  = (acc_addr_in >= mag_pkg::RAM_BASE) && (acc_addr_in <= mag_pkg::RAM_END);

  // ==========================================================================
  // access decode and next state
  always_comb begin
    next_st           = st;
    next_st.sys_reset = 1'b0;
    next_st.rsp_valid = 1'b0;
    v_range           = 1'b0;
    v_right           = 1'b0;
    v_reg             = 1'b0;
    rd_block          = 1'b0;
    phys              = acc_addr_in;
    unique case (acc_space_in)
      mag_pkg::SPC_CODE: begin
        if (acc_addr_in > mag_pkg::ROM_USR_END) begin
          v_range = 1'b1; // [R12]
        end else if (acc_kind_in == mag_pkg::KIND_WRITE) begin
          v_right = 1'b1; // [R11]
        end else if (user && acc_addr_in < mag_pkg::ROM_USR_BASE) begin
          v_right = 1'b1; // [R08] [R17]
        end else if (!user && acc_kind_in == mag_pkg::KIND_FETCH
                     && acc_addr_in >= mag_pkg::ROM_USR_BASE) begin
          v_right = 1'b1; // [R09] [R04]
        end
      end
      mag_pkg::SPC_XDATA: begin
        if (acc_kind_in == mag_pkg::KIND_FETCH) begin
          v_right = 1'b1;
        end else if (acc_addr_in <= mag_pkg::EEP_USR_END || in_ram) begin
          v_right = 1'b0;
        end else if (acc_addr_in >= mag_pkg::ROW_LOG_BASE
                     && acc_addr_in <= mag_pkg::ROW_LOG_END) begin
          phys = mag_pkg::ROW_PHYS_BASE + {9'h000, row_off}; // [R06] [R19]
          if (user && acc_kind_in == mag_pkg::KIND_WRITE) begin
            v_right = 1'b1; // [R10] [R05]
          end else if (user && !row_user_rd(row_off)) begin
            rd_block = 1'b1; // [R07]
          end
        end else begin
          v_range = 1'b1; // [R12]
        end
      end
      mag_pkg::SPC_REG: begin
        if (acc_addr_in < mag_pkg::REG_LO || acc_addr_in > mag_pkg::REG_HI) begin
          v_range = 1'b1;
        end else if (acc_kind_in == mag_pkg::KIND_FETCH) begin
          v_right = 1'b1;
        end else if (!reg_ok(acc_addr_in[7:0], user, acc_kind_in == mag_pkg::KIND_WRITE)) begin
          if (acc_kind_in == mag_pkg::KIND_WRITE) begin
            v_reg = 1'b1; // [R16] [R14]
          end else begin
            rd_block = 1'b1; // [R15] [R14]
          end
        end
      end
      default: begin
        v_range = 1'b1;
      end
    endcase

    // consistency of cache lines and ram reads
    c_err = (cache_valid_in && par(cache_addr_in, cache_data_in) != cache_par_in)
            || (acc_valid_in && acc_space_in == mag_pkg::SPC_XDATA && in_ram
                && acc_kind_in == mag_pkg::KIND_READ
                && par(acc_addr_in, mem_rdata_in) != mem_par_in); // [R13]

    if (acc_valid_in && v_range) begin
      cause_c = mag_pkg::CS_RANGE;
    end else if (acc_valid_in && v_reg) begin
      cause_c = mag_pkg::CS_REG;
    end else if (acc_valid_in && v_right) begin
      cause_c = mag_pkg::CS_MEM;
    end else if (c_err) begin
      cause_c = mag_pkg::CS_CONS;
    end else if (fuse_wr_in && user) begin
      cause_c = mag_pkg::CS_FUSE; // [R05]
    end else begin
      cause_c = mag_pkg::CS_NONE;
    end

    if (cause_c != mag_pkg::CS_NONE) begin
      next_st.sys_reset = 1'b1;
      next_st.cause     = cause_c; // [R18]
      next_st.mode      = mag_pkg::MD_BOOT; // [R20]
    end else begin
      if (acc_valid_in && acc_kind_in != mag_pkg::KIND_WRITE) begin
        next_st.rsp_valid = 1'b1;
        next_st.rdata     = rd_block ? mag_pkg::REG_FIXED_VAL : mem_rdata_in; // [R15]
      end
      unique case (st.mode)
        mag_pkg::MD_BOOT: begin
          if (boot_done_in) begin
            next_st.mode = (boot_test_sel_in && test_pin_s && !fuse_s)
                           ? mag_pkg::MD_SYSTEM : mag_pkg::MD_USER; // [R01] [R03]
          end
        end
        mag_pkg::MD_SYSTEM: begin
          if (long_call_instruction_in && long_call_target_in == mag_pkg::MODE_SW_ADDR) begin
            next_st.mode = mag_pkg::MD_USER; // [R02]
          end
        end
        mag_pkg::MD_USER: begin
          next_st.mode = mag_pkg::MD_USER; // [R02] [R17]
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st.mode      <= mag_pkg::MD_BOOT;
      st.rsp_valid <= 1'b0;
      st.rdata     <= mag_pkg::RDATA_RST;
      st.sys_reset <= 1'b0;
      st.cause     <= mag_pkg::CS_POWER;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs
  assign mem_en_out      = acc_valid_in && !v_range && !v_right && !v_reg && !rd_block;
  assign mem_we_out      = mem_en_out && (acc_kind_in == mag_pkg::KIND_WRITE);
  assign mem_addr_out    = phys;
  assign ram_par_out     = par(acc_addr_in, acc_wdata_in);
  assign fuse_wr_en_out  = fuse_wr_in && !user; // [R05]
  assign rsp_valid_out   = st.rsp_valid;
  assign rsp_rdata_out   = st.rdata;
  assign privileged_out  = !user;
  assign sys_reset_out   = st.sys_reset;
  assign reset_cause_out = st.cause;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_mode_one_way: assert property ( // [R02]
    user && !sys_reset_out |=> user || sys_reset_out)
    else $error("left user mode without a reset");

  a_fuse_blocks_test: assert property ( // [R03]
    st.mode == mag_pkg::MD_BOOT && boot_done_in && fuse_s && cause_c == mag_pkg::CS_NONE
    |=> st.mode == mag_pkg::MD_USER)
    else $error("test mode chosen with fuse blown");

  a_range_reset: assert property ( // [R12]
    acc_valid_in && acc_space_in == mag_pkg::SPC_CODE && acc_addr_in > mag_pkg::ROM_USR_END
    |-> !mem_en_out ##1 sys_reset_out && reset_cause_out == mag_pkg::CS_RANGE)
    else $error("out of range access without reset");

  a_sys_fetch_user: assert property ( // [R09]
    acc_valid_in && !user && acc_space_in == mag_pkg::SPC_CODE
    && acc_kind_in == mag_pkg::KIND_FETCH && acc_addr_in >= mag_pkg::ROM_USR_BASE
    |=> sys_reset_out)
    else $error("privileged fetch from application rom");

  a_user_rom_deny: assert property ( // [R08]
    acc_valid_in && user && acc_space_in == mag_pkg::SPC_CODE
    && acc_addr_in < mag_pkg::ROM_USR_BASE |-> !mem_en_out)
    else $error("user mode reached system rom");

  a_reg_wr_reset: assert property ( // [R16]
    acc_valid_in && acc_space_in == mag_pkg::SPC_REG && acc_kind_in == mag_pkg::KIND_WRITE
    && acc_addr_in[15:8] == 8'h00 && acc_addr_in[7:0] >= mag_pkg::REG_NIMP_BASE
    |=> sys_reset_out && reset_cause_out == mag_pkg::CS_REG)
    else $error("unimplemented register write without reset");

  a_reg_rd_fixed: assert property ( // [R15]
    acc_valid_in && user && acc_space_in == mag_pkg::SPC_REG
    && acc_kind_in == mag_pkg::KIND_READ && acc_addr_in[15:8] == 8'h00
    && acc_addr_in[7:0] >= mag_pkg::REG_SYS_BASE && !c_err
    |=> rsp_valid_out && rsp_rdata_out == mag_pkg::REG_FIXED_VAL)
    else $error("denied register read leaked data");

  a_row_user_ro: assert property ( // [R10]
    acc_valid_in && user && acc_space_in == mag_pkg::SPC_XDATA
    && acc_kind_in == mag_pkg::KIND_WRITE && acc_addr_in >= mag_pkg::ROW_LOG_BASE
    && acc_addr_in <= mag_pkg::ROW_LOG_END |-> !mem_we_out ##1 sys_reset_out)
    else $error("user write reached the row");

  a_reset_boot: assert property ( // [R20]
    sys_reset_out |-> st.mode == mag_pkg::MD_BOOT && privileged_out)
    else $error("violation reset did not restart boot");

  a_cause_hold: assert property ( // [R18]
    !next_st.sys_reset |=> $stable(reset_cause_out))
    else $error("reset cause changed without a reset");

  // ==========================================================================
  // mode, mapping and consistency
  a_boot_choice: assert property ( // [R01]
    st.mode == mag_pkg::MD_BOOT && boot_done_in && boot_test_sel_in
    && test_pin_s && !fuse_s && cause_c == mag_pkg::CS_NONE
    |=> st.mode == mag_pkg::MD_SYSTEM)
    else $error("test boot not in system mode");

  a_mode_switch: assert property ( // [R02]
    st.mode == mag_pkg::MD_SYSTEM && long_call_instruction_in
    && long_call_target_in == mag_pkg::MODE_SW_ADDR && cause_c == mag_pkg::CS_NONE
    |=> !privileged_out)
    else $error("switch call kept system mode");

  a_fuse_wr_gate: assert property ( // [R05]
    user && fuse_wr_in
    |-> !fuse_wr_en_out ##1 sys_reset_out)
    else $error("user fuse write not refused");

  a_row_map: assert property ( // [R06]
    acc_valid_in && acc_space_in == mag_pkg::SPC_XDATA
    && acc_kind_in != mag_pkg::KIND_FETCH
    && acc_addr_in >= mag_pkg::ROW_LOG_BASE && acc_addr_in <= mag_pkg::ROW_LOG_END
    |-> mem_addr_out[15:7] == mag_pkg::ROW_PHYS_BASE[15:7]
    && mem_addr_out[6:0] == acc_addr_in[6:0])
    else $error("row not mapped to eeprom top");

  a_fabkey_user: assert property ( // [R19]
    acc_valid_in && user && acc_space_in == mag_pkg::SPC_XDATA
    && acc_kind_in == mag_pkg::KIND_READ
    && acc_addr_in[15:7] == mag_pkg::ROW_LOG_BASE[15:7]
    && acc_addr_in[6:0] > mag_pkg::ROW_URD_LAST
    && acc_addr_in[6:0] <= mag_pkg::FAB_LAST
    |-> !mem_en_out)
    else $error("user read of hidden key byte");

  a_code_write: assert property ( // [R11]
    acc_valid_in && acc_space_in == mag_pkg::SPC_CODE
    && acc_kind_in == mag_pkg::KIND_WRITE
    |-> !mem_we_out ##1 sys_reset_out)
    else $error("code write not refused");

  a_xdata_range: assert property ( // [R12]
    acc_valid_in && acc_space_in == mag_pkg::SPC_XDATA
    && acc_kind_in != mag_pkg::KIND_FETCH
    && acc_addr_in > mag_pkg::RAM_END && acc_addr_in < mag_pkg::ROW_LOG_BASE
    |-> !mem_en_out ##1 sys_reset_out && reset_cause_out == mag_pkg::CS_RANGE)
    else $error("data range miss without reset");

  a_cons_reset: assert property ( // [R13]
    c_err && !(acc_valid_in && (v_range || v_right || v_reg))
    |=> sys_reset_out && reset_cause_out == mag_pkg::CS_CONS)
    else $error("consistency error without reset");

  a_reg_user_sys: assert property ( // [R17]
    acc_valid_in && user && acc_space_in == mag_pkg::SPC_REG
    && acc_addr_in[15:8] == 8'h00
    && acc_addr_in[7:0] >= mag_pkg::REG_SYS_BASE
    |-> !mem_en_out)
    else $error("user reached system register");

endmodule

`default_nettype wire

// ==== tb/mag_mem_model.sv ====
// memory side model answering guard reads with data and check bits
`timescale 1ns/10ps
`default_nettype none

module mag_mem_model (
  // clock
  input  wire logic        clk_in,
  // memory control from the guard and check bit fault request from the bench
  input  wire logic        en_in,
  input  wire logic        we_in,
  input  wire logic [15:0] addr_in,
  input  wire logic        bad_par_in,
  // read data and check bit
  output logic [7:0]       rdata_out,
  output logic             par_out
);
  // ==========================================================================
  // contents and idle pattern
  logic [7:0] junk;

  initial junk = 8'hA5;

  // an unselected memory shows a pattern that each clock inverts and mixes with the address low byte
  always @(posedge clk_in) begin
    junk <= ~junk ^ addr_in[7:0];
  end

  assign rdata_out = (en_in && !we_in) ? (addr_in[7:0] ^ addr_in[15:8] ^ 8'h5A) : junk;
  // a bad check bit is given only when the bench asks for one
  assign par_out   = ^{addr_in, rdata_out} ^ bad_par_in;
endmodule

`default_nettype wire

// ==== tb/mag_guard_bench.sv ====
// self-checking bench of the mode and access guard
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("ERROR %0t: got %h expected %h", $time, g, e); end end

module mag_guard_bench;
  // ==========================================================================
  // signals
  logic        clk_in, rstn_in, test_pin_in, fuse_blown_in, boot_done_in, boot_test_sel_in;
  logic        acc_valid_in, long_call_instruction_in, fuse_wr_in, mem_par_in, bad_par_in;
  logic        cache_valid_in, cache_par_in, mem_en_out, mem_we_out, ram_par_out, fuse_wr_en_out;
  logic        rsp_valid_out, privileged_out, sys_reset_out;
  logic [1:0]  acc_kind_in, acc_space_in;
  logic [2:0]  reset_cause_out, last_cause;
  logic [7:0]  acc_wdata_in, mem_rdata_in, cache_data_in, rsp_rdata_out;
  logic [12:0] e_m;
  logic [15:0] acc_addr_in, long_call_target_in, cache_addr_in, mem_addr_out, ra;
  logic [2:0]  bt;
  logic [12:0] q[$];
  int          n_fail = 0;
  int          n_checks = 0;

  localparam logic [1:0]  KF   = mag_pkg::KIND_FETCH;
  localparam logic [1:0]  KR   = mag_pkg::KIND_READ;
  localparam logic [1:0]  KW   = mag_pkg::KIND_WRITE;
  localparam logic [1:0]  SC   = mag_pkg::SPC_CODE;
  localparam logic [1:0]  SX   = mag_pkg::SPC_XDATA;
  localparam logic [1:0]  SS   = mag_pkg::SPC_REG;
  localparam logic [12:0] NONE = 13'h0000;
  // boot table {pin, fuse, request}, entry 0 in the low bits
  localparam logic [11:0] BT   = 12'h87D;

  // ==========================================================================
  // design and partner
  mag_guard dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .test_pin_in(test_pin_in),
    .fuse_blown_in(fuse_blown_in), .boot_done_in(boot_done_in), .boot_test_sel_in(boot_test_sel_in),
    .acc_valid_in(acc_valid_in), .acc_kind_in(acc_kind_in), .acc_space_in(acc_space_in),
    .acc_addr_in(acc_addr_in), .acc_wdata_in(acc_wdata_in),
    .long_call_instruction_in(long_call_instruction_in), .long_call_target_in(long_call_target_in),
    .fuse_wr_in(fuse_wr_in), .mem_rdata_in(mem_rdata_in), .mem_par_in(mem_par_in),
    .cache_valid_in(cache_valid_in), .cache_addr_in(cache_addr_in), .cache_data_in(cache_data_in),
    .cache_par_in(cache_par_in), .mem_en_out(mem_en_out), .mem_we_out(mem_we_out),
    .mem_addr_out(mem_addr_out), .ram_par_out(ram_par_out), .fuse_wr_en_out(fuse_wr_en_out),
    .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out), .privileged_out(privileged_out),
    .sys_reset_out(sys_reset_out), .reset_cause_out(reset_cause_out));

  mag_mem_model mem_u (.clk_in(clk_in), .en_in(mem_en_out), .we_in(mem_we_out), .addr_in(mem_addr_out),
    .bad_par_in(bad_par_in), .rdata_out(mem_rdata_in), .par_out(mem_par_in));

  // ==========================================================================
  // helpers
  function automatic logic [7:0] md(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  function automatic logic [12:0] rsp(input logic [7:0] d);
    return {2'b10, 3'h0, d};
  endfunction

  function automatic logic [12:0] vio(input logic [2:0] c);
    return {2'b11, c, 8'h00};
  endfunction

  task automatic acc(input logic [1:0] k, input logic [1:0] s, input logic [15:0] a,
                     input logic [12:0] e, input logic en);
    acc_valid_in = 1'b1;
    acc_kind_in = k;
    acc_space_in = s;
    acc_addr_in = a;
    acc_wdata_in = 8'($urandom);
    if (e[12]) q.push_back(e);
    #1;
    `CHK(mem_en_out, en)
    `CHK(mem_we_out, en & (k == KW))
    if (k == KW) `CHK(ram_par_out, ^{a, acc_wdata_in})
    @(posedge clk_in);
    #1;
  endtask

  task automatic boot(input logic tp, input logic fb, input logic sel);
    acc_valid_in = 1'b0;
    #2;
    `CHK(privileged_out, 1'b1)
    `CHK(reset_cause_out, last_cause)
    test_pin_in = tp;
    fuse_blown_in = fb;
    repeat (5) @(posedge clk_in);
    #1;
    boot_done_in = 1'b1;
    boot_test_sel_in = sel;
    @(posedge clk_in);
    #1;
    boot_done_in = 1'b0;
    `CHK(privileged_out, tp & ~fb & sel)
    fuse_wr_in = 1'b1;
    #1;
    `CHK(fuse_wr_en_out, tp & ~fb & sel)
    fuse_wr_in = 1'b0;
  endtask

  task automatic long_call_instruction(input logic [15:0] t, input logic exp);
    long_call_instruction_in = 1'b1;
    long_call_target_in = t;
    @(posedge clk_in);
    #1;
    `CHK(privileged_out, exp)
  endtask

  task automatic viol(input logic s, input logic [1:0] k, input logic [1:0] sp, input logic [15:0] a,
                      input logic [2:0] c);
    boot(s, 1'b0, s);
    acc(k, sp, a, vio(c), 1'b0);
  endtask

  task automatic test_done;
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================================
  // clock, watchdog and result monitor
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    repeat (5000) @(posedge clk_in);
    n_fail++;
    test_done;
  end

  always @(posedge clk_in) begin
    #2;
    if (rsp_valid_out === 1'b1 || sys_reset_out === 1'b1) begin
      if (q.size() == 0) begin
        n_fail++;
        $display("ERROR %0t: answer with nothing expected", $time);
      end else begin
        e_m = q.pop_front();
        `CHK(sys_reset_out, e_m[11])
        if (e_m[11]) begin
          last_cause = e_m[10:8];
          `CHK(reset_cause_out, e_m[10:8])
        end else `CHK(rsp_rdata_out, e_m[7:0])
      end
    end
  end

  // ==========================================================================
  // tests
  initial begin
    {rstn_in, test_pin_in, fuse_blown_in, boot_done_in, boot_test_sel_in, acc_valid_in} = '0;
    {long_call_instruction_in, fuse_wr_in, bad_par_in, cache_valid_in, cache_par_in} = '0;
    {acc_kind_in, acc_space_in, acc_wdata_in, acc_addr_in, long_call_target_in} = '0;
    {cache_data_in, cache_addr_in, ra} = '0;
    last_cause = mag_pkg::CS_POWER;
    repeat (16) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    void'($urandom(89798));
    for (int i = 0; i < 4; i++) begin
      bt = BT[i*3 +: 3];
      boot(bt[2], bt[1], bt[0]);
      acc(KF, SC, 16'hA000, vio(mag_pkg::CS_RANGE), 1'b0);
    end
    boot(1'b1, 1'b0, 1'b1);
    acc(KR, SX, 16'hF020, rsp(md(16'h0FA0)), 1'b1);
    acc(KW, SX, 16'hF010, NONE, 1'b1);
    acc(KW, SS, 16'h00E0, NONE, 1'b1);
    acc(KR, SS, 16'h00E0, rsp(md(16'h00E0)), 1'b1);
    acc(KF, SC, 16'h0100, rsp(md(16'h0100)), 1'b1);
    acc(KR, SC, 16'h2000, rsp(md(16'h2000)), 1'b1);
    acc(KF, SC, 16'h2000, vio(mag_pkg::CS_MEM), 1'b0);
    boot(1'b1, 1'b0, 1'b1);
    long_call_instruction(16'h2001, 1'b1);
    long_call_instruction(mag_pkg::MODE_SW_ADDR, 1'b0);
    long_call_instruction_in = 1'b0;
    boot_done_in = 1'b1;
    @(posedge clk_in);
    #1;
    boot_done_in = 1'b0;
    `CHK(privileged_out, 1'b0)
    acc(KR, SX, 16'hF000, rsp(md(16'h0F80)), 1'b1);
    acc(KR, SX, 16'hF01F, rsp(md(16'h0F9F)), 1'b1);
    acc(KR, SX, 16'hF020, rsp(8'hFF), 1'b0);
    acc(KR, SX, 16'hF03F, rsp(8'hFF), 1'b0);
    acc(KR, SX, 16'hF040, rsp(md(16'h0FC0)), 1'b1);
    acc(KR, SX, 16'hF07F, rsp(md(16'h0FFF)), 1'b1);
    acc(KR, SS, 16'h00C0, rsp(md(16'h00C0)), 1'b1);
    acc(KR, SS, 16'h00E0, rsp(8'hFF), 1'b0);
    acc(KR, SS, 16'h00F5, rsp(8'hFF), 1'b0);
    acc(KW, SS, 16'h0080, NONE, 1'b1);
    acc(KF, SC, 16'h2000, rsp(md(16'h2000)), 1'b1);
    acc(KW, SX, 16'h0F7F, NONE, 1'b1);
    for (int i = 0; i < 24; i++) begin
      ra = mag_pkg::RAM_BASE + 16'($urandom & 32'h7FF);
      if ($urandom & 1) acc(KW, SX, ra, NONE, 1'b1);
      else acc(KR, SX, ra, rsp(md(ra)), 1'b1);
    end
    acc(KR, SX, 16'h0F80, vio(mag_pkg::CS_RANGE), 1'b0);
    viol(1'b0, KW, SX, 16'hF000, mag_pkg::CS_MEM);
    viol(1'b0, KF, SC, 16'h0100, mag_pkg::CS_MEM);
    viol(1'b0, KW, SS, 16'h00C0, mag_pkg::CS_REG);
    viol(1'b0, KW, SS, 16'h00E0, mag_pkg::CS_REG);
    viol(1'b1, KW, SS, 16'h00F5, mag_pkg::CS_REG);
    viol(1'b0, KR, SX, 16'h1800, mag_pkg::CS_RANGE);
    viol(1'b0, KR, 2'h3, 16'h0000, mag_pkg::CS_RANGE);
    viol(1'b1, KW, SC, 16'h0100, mag_pkg::CS_MEM);
    boot(1'b0, 1'b0, 1'b0);
    bad_par_in = 1'b1;
    acc(KR, SX, 16'h1234, vio(mag_pkg::CS_CONS), 1'b1);
    bad_par_in = 1'b0;
    boot(1'b0, 1'b0, 1'b0);
    cache_addr_in = 16'($urandom);
    cache_data_in = 8'($urandom);
    cache_par_in = ^{cache_addr_in, cache_data_in};
    cache_valid_in = 1'b1;
    @(posedge clk_in);
    #1;
    q.push_back(vio(mag_pkg::CS_FUSE));
    fuse_wr_in = 1'b1;
    @(posedge clk_in);
    #1;
    q.push_back(vio(mag_pkg::CS_CONS));
    fuse_wr_in = 1'b0;
    cache_par_in = ~cache_par_in;
    @(posedge clk_in);
    #1;
    cache_valid_in = 1'b0;
    boot(1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge clk_in);
    `CHK(q.size(), 0)
    test_done;
  end
endmodule

`default_nettype wire
